// ### hw/lldram_pkg.sv
// Shared constants, types and clock-grouping functions for the low-latency DRAM pin block
package lldram_pkg;

  localparam int DQ_MAX = 36;
  localparam int ADDR_W = 8;
  localparam int HALF_W = ADDR_W / 2;
  localparam int MAX_RPAIRS = 4;
  localparam int GEN_TWO = 2;
  localparam int GEN_THREE = 3;
  localparam int BUS_X36 = 36;
  localparam int BUS_X18 = 18;
  localparam int BUS_X9 = 9;
  localparam int RD_LAT_DEF = 6;
  localparam int CNT_W = 8;
  // Read-valid leads data by one core cycle, which is half a read clock period
  localparam logic [CNT_W-1:0] VLD_LEAD_CYC = 8'h01;
  localparam logic [CNT_W-1:0] DATA_BEAT_CYC = 8'h02;
  // Edges after reset before the two-flop strap chain holds the pin value
  localparam logic [CNT_W-1:0] STRAP_SETTLE_CYC = 8'h02;

  typedef struct packed {
    logic cs_n;
    logic ref_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic mask;
    logic [DQ_MAX-1:0] data;
  } wr_word_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR_HI = 4'h2,
    ST_WR_WAIT = 4'h4,
    ST_RD_WAIT = 4'h8
  } core_state_t;

  typedef struct packed {
    core_state_t st;
    cmd_pins_t pin_a;
    cmd_pins_t pin_b;
    logic [1:0] mode_sync;
    logic mode_caught;
    logic mux_mode;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] cnt;
    logic req_tog;
    logic [2:0] ack_sync;
    logic [MAX_RPAIRS-1:0] rk_true;
    logic [MAX_RPAIRS-1:0] rk_comp;
    logic [DQ_MAX-1:0] q;
    logic qvalid;
  } core_reg_t;

  typedef struct packed {
    logic [2:0] req_sync;
    logic ack_tog;
    wr_word_t hold;
  } link_reg_t;

  // Number of read clock pairs for a generation and bus width; zero marks an illegal option
  function automatic int rd_pairs(input int gen, input int width);
    int n;
    n = 0;
    if (gen == GEN_TWO) begin
      if (width == BUS_X36) n = 2;
      else if (width == BUS_X18) n = 2;
      else if (width == BUS_X9) n = 1;
    end else if (gen == GEN_THREE) begin
      if (width == BUS_X36) n = 4;
      else if (width == BUS_X18) n = 2;
    end
    return n;
  endfunction

  // Number of write clock pairs for a generation and bus width
  function automatic int wr_pairs(input int gen, input int width);
    int n;
    n = 0;
    if (gen == GEN_TWO) begin
      if (width == BUS_X36) n = 2;
      else if (width == BUS_X18 || width == BUS_X9) n = 1;
    end else if (gen == GEN_THREE) begin
      if (width == BUS_X36 || width == BUS_X18) n = 2;
    end
    return n;
  endfunction

endpackage

// ### hw/write_capture.sv
// Write data capture on the write data clock with a toggle handshake to the core
`timescale 1ns/1ps
module write_capture
  import lldram_pkg::*;
(
  input wire logic wclk_i,
  input wire logic rst_i,
  input wire logic req_tog_i,
  input wire logic [DQ_MAX-1:0] write_data_i,
  input wire logic write_byte_mask_i,
  output logic ack_tog_o,
  output wr_word_t word_o
);

  link_reg_t r;
  link_reg_t next_r;

  always_comb begin
    next_r = r;
    next_r.req_sync = {r.req_sync[1:0], req_tog_i};
    // Word is centred on the clock edge by the controller, so one rising edge takes it
    if (r.req_sync[2] != r.req_sync[1]) begin
      next_r.hold.data = write_data_i;
      next_r.hold.mask = write_byte_mask_i;
      next_r.ack_tog = ~r.ack_tog;
    end
  end

  always_ff @(posedge wclk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Hold only changes on a new request, so the core may read it after the ack crosses
  assign ack_tog_o = r.ack_tog;
  assign word_o = r.hold;

endmodule

// ### hw/lldram_pins.sv
// Memory-side pin logic of a low-latency DRAM: command capture, array, read clocks and valid
//
// What this block does
// - Commands and address are taken once per command clock cycle on its rising edge only.
// - Writes come with a free-running write clock and reads leave with free-running read clocks.
// - Second generation: x36 has two write and two read pairs, x18 one and two, x9 one and one.
// - Third generation: x36 has two write and four read pairs, x18 two and two, no x9.
// - Address arrives whole in one cycle, or split over two cycles on the low pins.
// - Read data leaves edge-aligned with the read clocks; write data arrives centred on its clock.
// - Read-valid follows the read clock edges and rises half a clock before read data.
`timescale 1ns/1ps
module lldram_pins
  import lldram_pkg::*;
#(
  parameter int GEN = GEN_TWO,
  parameter int BUS_WIDTH = BUS_X36,
  parameter int RD_LAT = RD_LAT_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic write_data_clock_true_i,
  input wire logic cs_n_i,
  input wire logic ref_n_i,
  input wire logic we_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic addr_mux_mode_i,
  input wire logic [DQ_MAX-1:0] write_data_i,
  input wire logic write_byte_mask_i,
  output logic [DQ_MAX-1:0] read_data_o,
  output logic read_valid_flag_o,
  output logic [MAX_RPAIRS-1:0] read_data_clock_true_o,
  output logic [MAX_RPAIRS-1:0] read_data_clock_comp_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration

  localparam int RPAIRS = rd_pairs(GEN, BUS_WIDTH);
  localparam int WPAIRS = wr_pairs(GEN, BUS_WIDTH);
  localparam logic [MAX_RPAIRS-1:0] RPAIR_MASK = MAX_RPAIRS'((1 << RPAIRS) - 1);
  localparam logic [DQ_MAX-1:0] DQ_MASK = DQ_MAX'((64'h1 << BUS_WIDTH) - 64'h1);
  localparam logic [CNT_W-1:0] RD_LAT_CNT = CNT_W'(RD_LAT);
  localparam int DEPTH = 1 << ADDR_W;

  // An illegal generation and width pair has no clock pairs: read clocks stay low, commands ignored
  localparam logic CFG_OK = (RPAIRS != 0) && (WPAIRS != 0);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and write path

  logic [DQ_MAX-1:0] mem [DEPTH];
  core_reg_t r;
  core_reg_t next_r;
  wr_word_t link_word;
  logic link_ack_tog;
  logic mem_we;

  write_capture u_wcap (
    .wclk_i(write_data_clock_true_i),
    .rst_i(rst_i),
    .req_tog_i(r.req_tog),
    .write_data_i(write_data_i),
    .write_byte_mask_i(write_byte_mask_i),
    .ack_tog_o(link_ack_tog),
    .word_o(link_word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core state

  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    next_r.pin_a = '{cs_n: cs_n_i, ref_n: ref_n_i, we_n: we_n_i, addr: addr_i};
    next_r.pin_b = r.pin_a;
    next_r.mode_sync = {r.mode_sync[0], addr_mux_mode_i};
    next_r.ack_sync = {r.ack_sync[1:0], link_ack_tog};
    // Strap is taken once the sync chain has filled after reset; later changes have no effect
    if (!r.mode_caught) begin
      next_r.cnt = r.cnt + 8'h01;
      if (r.cnt == STRAP_SETTLE_CYC) begin
        next_r.mux_mode = r.mode_sync[1];
        next_r.mode_caught = 1'b1;
      end
    end
    // Read clocks run free from reset, one toggle per core edge
    next_r.rk_true = ~r.rk_true & RPAIR_MASK;
    next_r.rk_comp = ~next_r.rk_true & RPAIR_MASK;
    case (r.st)
      ST_IDLE: begin
        // Low select with refresh low is a refresh: nothing to do for this array
        if (CFG_OK && r.mode_caught && !r.pin_b.cs_n && r.pin_b.ref_n) begin
          if (r.mux_mode) begin
            next_r.addr = {{HALF_W{1'b0}}, r.pin_b.addr[HALF_W-1:0]};
            next_r.st = ST_ADDR_HI;
          end else begin
            next_r.addr = r.pin_b.addr;
            next_r.st = r.pin_b.we_n ? ST_RD_WAIT : ST_WR_WAIT;
            next_r.cnt = RD_LAT_CNT;
            next_r.req_tog = r.req_tog ^ ~r.pin_b.we_n;
          end
        end
      end
      ST_ADDR_HI: begin
        // Command kind is taken from we_n in the second cycle, which also carries the upper bits
        next_r.addr[ADDR_W-1:HALF_W] = r.pin_b.addr[HALF_W-1:0];
        next_r.st = r.pin_b.we_n ? ST_RD_WAIT : ST_WR_WAIT;
        next_r.cnt = RD_LAT_CNT;
        next_r.req_tog = r.req_tog ^ ~r.pin_b.we_n;
      end
      ST_WR_WAIT: begin
        if (r.ack_sync[2] != r.ack_sync[1]) begin
          mem_we = ~link_word.mask;
          next_r.st = ST_IDLE;
        end
      end
      ST_RD_WAIT: begin
        next_r.cnt = r.cnt - 8'h01;
        next_r.qvalid = (r.cnt != 8'h00) && (r.cnt <= DATA_BEAT_CYC + VLD_LEAD_CYC);
        if (r.cnt == DATA_BEAT_CYC) begin
          next_r.q = mem[r.addr] & DQ_MASK;
        end
        if (r.cnt == 8'h00) begin
          next_r.q = '0;
          next_r.st = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{st: ST_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[r.addr] <= link_word.data & DQ_MASK;
    end
  end

  assign read_data_o = r.q;
  assign read_valid_flag_o = r.qvalid;
  assign read_data_clock_true_o = r.rk_true;
  assign read_data_clock_comp_o = r.rk_comp;

endmodule

// ### test/ctrl_partner.sv
// Controller-side model: free-running write clock with centred write data and mask
`timescale 1ns/1ps
module ctrl_partner
  import lldram_pkg::*;
(
  input wire logic [DQ_MAX-1:0] data_i,
  input wire logic mask_i,
  output logic wclk_o,
  output logic [DQ_MAX-1:0] write_data_o,
  output logic write_byte_mask_o
);
  initial begin
    wclk_o = 1'b0;
    write_data_o = '0;
    write_byte_mask_o = 1'b0;
    #3.1;
    forever #6 wclk_o = ~wclk_o;
  end
  // Launch on the falling edge so the rising edge lands mid-bit
  always @(negedge wclk_o) begin
    write_data_o <= data_i;
    write_byte_mask_o <= mask_i;
  end
endmodule

// ### test/lldram_pins_assertions.sv
// Assertions on the pin behaviour of lldram_pins
`timescale 1ns/1ps
module lldram_pins_assertions
  import lldram_pkg::*;
#(
  parameter int RD_LAT = RD_LAT_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ref_n_i,
  input wire logic we_n_i,
  input wire logic [DQ_MAX-1:0] read_data_o,
  input wire logic read_valid_flag_o,
  input wire logic [MAX_RPAIRS-1:0] read_data_clock_true_o,
  input wire logic [MAX_RPAIRS-1:0] read_data_clock_comp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pair_inverse: assert property (!$past(rst_i) |->
    read_data_clock_comp_o[1:0] == ~read_data_clock_true_o[1:0]) else $error("legs not inverse");
  a_unused_pairs: assert property (read_data_clock_true_o[3:2] == 2'h0 &&
    read_data_clock_comp_o[3:2] == 2'h0) else $error("unused read pair active");
  a_clock_runs: assert property (!$past(rst_i) |->
    read_data_clock_true_o[1:0] == ~$past(read_data_clock_true_o[1:0])) else $error("read clock stuck");
  a_valid_lead: assert property ($rose(read_valid_flag_o) |-> read_data_o == '0)
    else $error("data with valid edge");
  a_valid_len: assert property ($rose(read_valid_flag_o) |->
    read_valid_flag_o [*3] ##1 !read_valid_flag_o) else $error("valid length wrong");
  a_data_idle: assert property (!read_valid_flag_o |-> read_data_o == '0)
    else $error("data outside valid");
  a_data_hold: assert property ($rose(read_valid_flag_o) |->
    ##2 $stable(read_data_o) ##1 read_data_o == '0) else $error("data beat wrong");
  a_read_latency: assert property ($rose(read_valid_flag_o) |->
    !$past(cs_n_i, RD_LAT + 1) && $past(ref_n_i, RD_LAT + 1) && $past(we_n_i, RD_LAT + 1))
    else $error("valid without read command");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |-> !read_valid_flag_o)
    else $error("valid in reset");
  c_read: cover property ($rose(read_valid_flag_o));
  c_write: cover property (!cs_n_i && ref_n_i && !we_n_i);
  c_refresh: cover property (!cs_n_i && !ref_n_i);
endmodule

bind lldram_pins lldram_pins_assertions #(.RD_LAT(RD_LAT)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .cs_n_i(cs_n_i), .ref_n_i(ref_n_i), .we_n_i(we_n_i), .read_data_o(read_data_o),
  .read_valid_flag_o(read_valid_flag_o), .read_data_clock_true_o(read_data_clock_true_o),
  .read_data_clock_comp_o(read_data_clock_comp_o));

// ### test/lldram_pins_tb.sv
// Self-checking bench for lldram_pins
`timescale 1ns/1ps
module lldram_pins_tb
  import lldram_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b1;
  logic ref_n = 1'b1;
  logic we_n = 1'b1;
  logic pm = 1'b0;
  logic mux_strap = 1'b0;
  logic vprev = 1'b0;
  logic wclk, wmask, vld;
  logic [ADDR_W-1:0] addr = '0;
  logic [ADDR_W-1:0] ad [5];
  logic [DQ_MAX-1:0] pd = '0;
  logic [DQ_MAX-1:0] wdat, rd_q;
  logic [DQ_MAX-1:0] mem_m [logic [ADDR_W-1:0]];
  logic [DQ_MAX-1:0] exp_q [$];
  logic [MAX_RPAIRS-1:0] rkt, rkc;
  int n_fail = 0;
  int n_compared = 0;
  ctrl_partner ctl (.data_i(pd), .mask_i(pm), .wclk_o(wclk), .write_data_o(wdat),
    .write_byte_mask_o(wmask));
  lldram_pins dut (.clk_i(clk_i), .rst_i(rst_i), .write_data_clock_true_i(wclk),
    .cs_n_i(cs_n), .ref_n_i(ref_n), .we_n_i(we_n), .addr_i(addr), .addr_mux_mode_i(mux_strap),
    .write_data_i(wdat), .write_byte_mask_i(wmask), .read_data_o(rd_q),
    .read_valid_flag_o(vld), .read_data_clock_true_o(rkt), .read_data_clock_comp_o(rkc));
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [DQ_MAX-1:0] got, input logic [DQ_MAX-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected read data at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One command cycle (two when multiplexed), then room for the read or write to finish
  task automatic cmd(input logic r, input logic w, input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    #1;
    {cs_n, ref_n, we_n, addr} = {1'b0, r, w, a};
    // Second half keeps the command and puts the upper address half on the low pins
    if (mux_strap) begin
      @(posedge clk_i);
      #1;
      addr = {a[HALF_W-1:0], a[ADDR_W-1:HALF_W]};
    end
    @(posedge clk_i);
    #1;
    cs_n = 1'b1;
    repeat (14) @(posedge clk_i);
    #1;
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  always @(posedge clk_i) begin
    #2;
    if (vld === 1'b1 && vprev !== 1'b1) begin
      @(posedge clk_i);
      #2;
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("unexpected valid at %0t", $time);
      end else chk(rd_q, exp_q.pop_front());
    end
    vprev = vld;
  end
  initial begin
    void'($urandom(32'hD168));
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    for (int i = 0; i < 5; i++) begin
      ad[i] = (i == 0) ? 8'h00 : (i == 1 || i == 4) ? 8'hFF : ADDR_W'($urandom);
      pd = DQ_MAX'({$urandom, $urandom});
      pm = (i == 4);
      if (!pm) mem_m[ad[i]] = pd;
      cmd(1'b1, 1'b0, ad[i]);
    end
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(mem_m[ad[i]]);
      cmd(1'b1, 1'b1, ad[i]);
    end
    // Second reset with the strap set; the array keeps its contents across it
    rst_i = 1'b1;
    mux_strap = 1'b1;
    pm = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    ad[0] = 8'h3C;
    ad[1] = ADDR_W'($urandom);
    for (int i = 0; i < 2; i++) begin
      pd = DQ_MAX'({$urandom, $urandom});
      mem_m[ad[i]] = pd;
      cmd(1'b1, 1'b0, ad[i]);
    end
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(mem_m[ad[i]]);
      cmd(1'b1, 1'b1, ad[i]);
    end
    cmd(1'b0, 1'b1, 8'h55);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("unexpected missing read data at %0t", $time);
    end
    finish_test();
  end
endmodule
